//--- bitmap_lcd_command_core.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - 2560-bit memory, one bit per dot
// - host access independent of refresh readout
// - column-to-segment mapping reversible
// - timing for 1/16 or 1/32 duty
// - master and slave scan kept synchronised
// - latch one 80-bit line per common
// - on/off and static act on latch
// - four drive levels per segment
// - frame square wave; slave aligns to it
// - reset pin edge fully initialises
// - reset pin level picks bus style
// - soft reset sets line, page only
// - select line plus strobes classify transfers
// - commands run on internal timing
// - display on/off from lowest bit
// - off plus static gives power save
// - start line selects first common line
// - page command loads page register
// - top bit zero loads column, except in rmw
// - data access advances column
// - rmw reads keep column
// - end restores saved column
// - status bits busy, order, display, reset
// - order bit: normal or reversed
// - duty bit: zero 1/16, one 1/32
module bitmap_lcd_command_core #(
  parameter int LINE_CYCLES = lcd_core_pkg::LINE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resetPinN,
  input wire logic masterSel,
  input wire logic frameIn,
  output logic frameOut,
  output logic frameOe,
  output logic [4:0] commonLine,
  output logic commonActive,
  output logic commonDir,
  output lcd_core_pkg::seg_level_t segLevel [80]
);
  typedef struct packed {
    logic [2:0] pinSync;
    logic pinLast;
    logic pinSeen;
    logic [1:0] frameSync;
    logic frameLast;
    logic bus80;
    logic dispOff;
    logic staticOn;
    logic orderNormal;
    logic duty32;
    logic rmw;
    logic [6:0] col;
    logic [6:0] colSaved;
    logic [1:0] page;
    logic [4:0] startLine;
    logic [4:0] lineCnt;
    logic [4:0] lineIdx;
    logic [31:0] tick;
    logic frame;
    logic [1:0] initCnt;
    logic [7:0] rdHold;
    logic [79:0] latchBits;
    logic [31:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;
  lcd_ram_if ram ();

  logic access;
  logic wrCmd;
  logic wrData;
  logic rdData;
  logic rdStatus;
  logic pinEdge;
  logic slaveAlign;
  logic lineTick;
  logic isSlave;
  logic blank;
  logic [7:0] cmd;
  logic [6:0] colMapped;
  logic [79:0] mappedLine;
  logic [4:0] lastLine;
  logic [7:0] status;

  lcd_display_ram u_ram (
    .clk_sys(clk_sys),
    .ram(ram)
  );

  // no wait states; every access finishes in its access phase
  assign access = psel && penable;
  assign pready = 1'b1;
  assign cmd = pwdata[7:0];
  assign isSlave = !masterSel;
  assign pslverr = access && !(paddr == lcd_core_pkg::ADDR_CMD ||
    paddr == lcd_core_pkg::ADDR_DATA || paddr == lcd_core_pkg::ADDR_STATUS ||
    paddr == lcd_core_pkg::ADDR_CTRL);
  // command/data select is the address word, strobe is pwrite
  assign wrCmd = access && pwrite && paddr == lcd_core_pkg::ADDR_CMD;
  assign wrData = access && pwrite && paddr == lcd_core_pkg::ADDR_DATA;
  assign rdData = access && !pwrite && paddr == lcd_core_pkg::ADDR_DATA;
  assign rdStatus = access && !pwrite && paddr == lcd_core_pkg::ADDR_STATUS;
  assign pinEdge = cur_ff.pinSeen && (cur_ff.pinSync[1] != cur_ff.pinLast);
  assign slaveAlign = isSlave && (cur_ff.frameSync[1] != cur_ff.frameLast);
  assign lineTick = cur_ff.tick == 32'(LINE_CYCLES - 1);
  assign lastLine = cur_ff.duty32 ? lcd_core_pkg::LINES32_LAST
    : lcd_core_pkg::LINES16_LAST;
  assign blank = cur_ff.dispOff && cur_ff.staticOn;
  assign status = {cur_ff.initCnt != 2'h0, !cur_ff.orderNormal,
    cur_ff.dispOff, cur_ff.initCnt != 2'h0, 4'h0};

  // ram ports
  assign ram.wrEn = wrData && cur_ff.initCnt == 2'h0;
  assign ram.wrPage = cur_ff.page;
  assign ram.wrCol = cur_ff.col;
  assign ram.wrData = cmd;
  assign ram.rdPage = cur_ff.page;
  assign ram.rdCol = cur_ff.col;
  assign ram.lineAddr = cur_ff.lineCnt;

  // column n of memory goes to segment n or 79-n
  genvar s;
  generate
    for (s = 0; s < lcd_core_pkg::COLS; s++) begin : g_map
      assign mappedLine[s] = cur_ff.orderNormal ? ram.lineBits[s]
        : ram.lineBits[lcd_core_pkg::COLS - 1 - s];
    end
  endgenerate
  assign colMapped = cur_ff.col;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.pinSync = {cur_ff.pinSync[1:0], resetPinN};
    nxt_ff.pinLast = cur_ff.pinSync[1];
    nxt_ff.pinSeen = 1'b1;
    nxt_ff.frameSync = {cur_ff.frameSync[0], frameIn};
    nxt_ff.frameLast = cur_ff.frameSync[1];
    if (cur_ff.initCnt != 2'h0) begin
      nxt_ff.initCnt = cur_ff.initCnt - 2'h1;
    end
    // line timing, master paces, slave realigns on frame edges
    nxt_ff.tick = lineTick ? 32'h0 : cur_ff.tick + 32'h1;
    if (slaveAlign) begin
      nxt_ff.tick = 32'h0;
      nxt_ff.lineIdx = 5'h0;
      nxt_ff.lineCnt = cur_ff.startLine;
      nxt_ff.latchBits = mappedLine;
    end else if (lineTick) begin
      nxt_ff.latchBits = mappedLine;
      // wrap also when a duty change leaves the index past the new end
      if (cur_ff.lineIdx >= lastLine) begin
        nxt_ff.lineIdx = 5'h0;
        nxt_ff.lineCnt = cur_ff.startLine;
        if (!isSlave) begin
          nxt_ff.frame = !cur_ff.frame;
        end
      end else begin
        nxt_ff.lineIdx = cur_ff.lineIdx + 5'h1;
        nxt_ff.lineCnt = cur_ff.lineCnt + 5'h1;
      end
    end
    if (isSlave) begin
      nxt_ff.frame = cur_ff.frameSync[1];
    end
    // host commands; swrst accepted while busy
    if (wrCmd && (cur_ff.initCnt == 2'h0 || cmd == lcd_core_pkg::OP_SWRST))
    begin
      if (!cmd[7]) begin
        if (!cur_ff.rmw) begin
          nxt_ff.col = cmd[6:0];
        end
      end else if (cmd[7:1] == lcd_core_pkg::OP_DISP) begin
        nxt_ff.dispOff = !cmd[0];
      end else if (cmd[7:1] == lcd_core_pkg::OP_ORDER) begin
        nxt_ff.orderNormal = cmd[0];
      end else if (cmd[7:1] == lcd_core_pkg::OP_STATIC) begin
        nxt_ff.staticOn = cmd[0];
      end else if (cmd[7:1] == lcd_core_pkg::OP_DUTY) begin
        nxt_ff.duty32 = cmd[0];
      end else if (cmd[7:2] == lcd_core_pkg::OP_PAGE) begin
        nxt_ff.page = cmd[1:0];
      end else if (cmd[7:5] == lcd_core_pkg::OP_LINE) begin
        nxt_ff.startLine = cmd[4:0];
      end else if (cmd == lcd_core_pkg::OP_RMW) begin
        nxt_ff.rmw = 1'b1;
        nxt_ff.colSaved = cur_ff.col;
      end else if (cmd == lcd_core_pkg::OP_END) begin
        nxt_ff.rmw = 1'b0;
        nxt_ff.col = cur_ff.colSaved;
      end else if (cmd == lcd_core_pkg::OP_SWRST) begin
        nxt_ff.startLine = lcd_core_pkg::LINE_RESET;
        nxt_ff.page = lcd_core_pkg::PAGE_RESET;
        nxt_ff.initCnt = 2'h1;
      end
    end
    // column advances and locks at the stop value
    if ((wrData || (rdData && !cur_ff.rmw)) && cur_ff.initCnt == 2'h0 &&
        cur_ff.col < lcd_core_pkg::COL_STOP) begin
      nxt_ff.col = colMapped + 7'h1;
    end
    // data reads: byte also kept in rdHold; host sees the rdata word
    if (rdData) begin
      nxt_ff.rdHold = ram.rdData;
    end
    // read word held until the next read setup, so it stands at the access edge
    if (psel && !penable && !pwrite) begin
      case (paddr)
        lcd_core_pkg::ADDR_DATA: nxt_ff.rdata = {24'h0, ram.rdData};
        lcd_core_pkg::ADDR_STATUS: nxt_ff.rdata = {24'h0, status};
        lcd_core_pkg::ADDR_CTRL: nxt_ff.rdata = 32'({blank, cur_ff.bus80,
          cur_ff.pinSync[1], masterSel});
        default: nxt_ff.rdata = 32'h0;
      endcase
    end
    // pin edge: full initialisation, then level decides bus style
    if (pinEdge) begin
      nxt_ff.dispOff = 1'b1;
      nxt_ff.startLine = lcd_core_pkg::LINE_RESET;
      nxt_ff.staticOn = 1'b0;
      nxt_ff.col = 7'h0;
      nxt_ff.page = lcd_core_pkg::PAGE_RESET;
      nxt_ff.duty32 = 1'b1;
      nxt_ff.orderNormal = 1'b0;
      nxt_ff.rmw = 1'b0;
      nxt_ff.initCnt = 2'h3;
      nxt_ff.bus80 = !cur_ff.pinSync[1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.dispOff <= 1'b1;
      cur_ff.duty32 <= 1'b1;
      cur_ff.page <= lcd_core_pkg::PAGE_RESET;
      cur_ff.initCnt <= 2'h3;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  lcd_seg_drive u_seg (
    .clk_sys(clk_sys),
    .rst(rst),
    .latchBits(cur_ff.dispOff ? 80'h0 : mappedLine & 80'h0 | cur_ff.latchBits
      | {80{cur_ff.staticOn}}),
    .frame(cur_ff.frame),
    .blank(blank),
    .segLevel(segLevel)
  );

  // deselected host traffic never reaches the decode (psel gates all)
  assign prdata = cur_ff.rdata;
  assign frameOut = cur_ff.frame;
  assign frameOe = masterSel;
  assign commonLine = cur_ff.lineIdx;
  assign commonActive = !blank;
  assign commonDir = isSlave;
endmodule : bitmap_lcd_command_core

//--- lcd_core_pkg.sv
package lcd_core_pkg;
  localparam int COLS = 80;
  localparam int PAGES = 4;
  localparam int LINES = 32;
  localparam int RAM_BITS = 2560;
  localparam logic [6:0] COL_LAST = 7'h4F;
  localparam logic [6:0] COL_STOP = 7'h50;
  localparam logic [1:0] PAGE_RESET = 2'h3;
  localparam logic [4:0] LINE_RESET = 5'h00;
  localparam logic [4:0] LINES16_LAST = 5'h0F;
  localparam logic [4:0] LINES32_LAST = 5'h1F;
  // apb map, byte addresses, word-aligned
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  // command opcodes
  localparam logic [6:0] OP_DISP = 7'h57;
  localparam logic [6:0] OP_ORDER = 7'h50;
  localparam logic [6:0] OP_STATIC = 7'h52;
  localparam logic [6:0] OP_DUTY = 7'h54;
  localparam logic [7:0] OP_RMW = 8'hE0;
  localparam logic [7:0] OP_END = 8'hEE;
  localparam logic [7:0] OP_SWRST = 8'hE2;
  localparam logic [5:0] OP_PAGE = 6'h2E;
  localparam logic [2:0] OP_LINE = 3'h6;
  localparam int ST_BUSY = 7;
  localparam int ST_ORDER = 6;
  localparam int ST_DISP = 5;
  localparam int ST_RESET = 4;
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_RSTPIN = 1;
  localparam int CTRL_BUS80 = 2;
  localparam int CTRL_SLEEP = 3;
  // lcd timing
  localparam int CLK_HZ = 125000000;
  localparam int LINE_HZ = 2000;
  localparam int LINE_CYC = CLK_HZ / LINE_HZ;
  typedef enum logic [3:0] {
    LV_HIGH = 4'b0001,
    LV_MID2 = 4'b0010,
    LV_MID3 = 4'b0100,
    LV_LOW = 4'b1000
  } seg_level_t;
endpackage : lcd_core_pkg

//--- lcd_ram_if.sv
`timescale 1ns/1ns
interface lcd_ram_if;
  logic wrEn;
  logic [1:0] wrPage;
  logic [6:0] wrCol;
  logic [7:0] wrData;
  logic [6:0] rdCol;
  logic [1:0] rdPage;
  logic [7:0] rdData;
  logic [4:0] lineAddr;
  logic [79:0] lineBits;
  modport core (output wrEn, wrPage, wrCol, wrData, rdCol, rdPage, lineAddr,
    input rdData, lineBits);
  modport mem (input wrEn, wrPage, wrCol, wrData, rdCol, rdPage, lineAddr,
    output rdData, lineBits);
endinterface : lcd_ram_if

//--- lcd_display_ram.sv
`timescale 1ns/1ns
module lcd_display_ram (
  input wire logic clk_sys,
  lcd_ram_if.mem ram
);
  // 4 pages x 80 columns x 8 bits; host port and refresh port separate
  logic [7:0] mem_ff [lcd_core_pkg::PAGES][lcd_core_pkg::COLS];

  always_ff @(posedge clk_sys) begin
    if (ram.wrEn && ram.wrCol <= lcd_core_pkg::COL_LAST) begin
      mem_ff[ram.wrPage][ram.wrCol] <= ram.wrData;
    end
  end

  always_comb begin
    ram.rdData = 8'h00;
    if (ram.rdCol <= lcd_core_pkg::COL_LAST) begin
      ram.rdData = mem_ff[ram.rdPage][ram.rdCol];
    end
  end

  // refresh readout path independent of host port
  genvar c;
  generate
    for (c = 0; c < lcd_core_pkg::COLS; c++) begin : g_line
      assign ram.lineBits[c] =
        mem_ff[ram.lineAddr[4:3]][c][ram.lineAddr[2:0]];
    end
  endgenerate
endmodule : lcd_display_ram

//--- lcd_seg_drive.sv
`timescale 1ns/1ns
module lcd_seg_drive (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [79:0] latchBits,
  input wire logic frame,
  input wire logic blank,
  output lcd_core_pkg::seg_level_t segLevel [80]
);
  genvar s;
  generate
    for (s = 0; s < lcd_core_pkg::COLS; s++) begin : g_seg
      always_ff @(posedge clk_sys) begin
        if (rst || blank) begin
          segLevel[s] <= lcd_core_pkg::LV_HIGH;
        end else begin
          case ({frame, latchBits[s]})
            2'b11: segLevel[s] <= lcd_core_pkg::LV_HIGH;
            2'b10: segLevel[s] <= lcd_core_pkg::LV_MID2;
            2'b01: segLevel[s] <= lcd_core_pkg::LV_LOW;
            default: segLevel[s] <= lcd_core_pkg::LV_MID3;
          endcase
        end
      end
    end
  endgenerate
endmodule : lcd_seg_drive

//--- lcd_core_assertions.sv
`timescale 1ns/1ns
module lcd_core_assertions #(
  parameter int LINE_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic resetPinN,
  input wire logic masterSel,
  input wire logic frameIn,
  input wire logic frameOut,
  input wire logic frameOe,
  input wire logic [4:0] commonLine,
  input wire logic commonActive,
  input wire logic commonDir,
  input wire lcd_core_pkg::seg_level_t segLevel [80]
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence apbAccess;
    psel && penable;
  endsequence
  sequence statusRead;
    apbAccess ##0 !pwrite && paddr == lcd_core_pkg::ADDR_STATUS;
  endsequence
  bad_addr_a: assert property (apbAccess ##0 paddr > 8'h0C |-> pslverr)
    else $error("unmapped access without error");
  quiet_err_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside an access");
  zero_wait_a: assert property (apbAccess |-> pready)
    else $error("access not answered at once");
  status_low_a: assert property (statusRead |-> prdata[3:0] == 4'h0)
    else $error("status low bits not zero");
  frame_dir_a: assert property (frameOe == masterSel)
    else $error("frame pin direction wrong");
  slave_scan_a: assert property (commonDir == !masterSel)
    else $error("scan direction wrong");
  line_step_a: assert property ($changed(commonLine) && masterSel
    && !$past(rst) |-> commonLine == $past(commonLine) + 5'h01
    || commonLine == 5'h00) else $error("common line skipped");
  level_hot_a: assert property ($onehot(segLevel[0])
    && $onehot(segLevel[79])) else $error("segment level not one-hot");
  save_drive_a: assert property (!commonActive [*2]
    |-> segLevel[0] == lcd_core_pkg::LV_HIGH) else $error("save level");
endmodule : lcd_core_assertions

//--- host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk_sys,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // entered just after a rising edge; ends one idle cycle later
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask : xfer
endmodule : host_bus_model

//--- tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
  localparam logic [7:0] AC = lcd_core_pkg::ADDR_CMD;
  localparam logic [7:0] AD = lcd_core_pkg::ADDR_DATA;
  localparam logic [7:0] AS = lcd_core_pkg::ADDR_STATUS;
  localparam logic [7:0] AK = lcd_core_pkg::ADDR_CTRL;
  logic clk_sys, rst, resetPinN, masterSel, frameIn, lastErr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic frameOut, frameOe, commonActive, commonDir;
  logic [4:0] commonLine;
  lcd_core_pkg::seg_level_t segLevel [80];
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  bitmap_lcd_command_core #(.LINE_CYCLES(4)) dut (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resetPinN(resetPinN), .masterSel(masterSel),
    .frameIn(frameIn), .frameOut(frameOut), .frameOe(frameOe),
    .commonLine(commonLine), .commonActive(commonActive),
    .commonDir(commonDir), .segLevel(segLevel));
  host_bus_model host (.clk_sys(clk_sys), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, {24'h000000, d}, q, lastErr);
  endtask : wr
  task automatic ck(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h00000000, q, lastErr);
    `CHK(q[7:0], x)
  endtask : ck
  task automatic idle;
    logic [31:0] q;
    q = 32'h000000FF;
    while (q[7] !== 1'b0) host.xfer(1'b0, AS, 32'h00000000, q, lastErr);
  endtask : idle
  // settle first: the old duty may still be mid-scan
  task automatic scan(input logic [4:0] top);
    logic [4:0] mx;
    logic fr;
    int flips;
    mx = 5'h00;
    flips = 0;
    repeat (70) @(posedge clk_sys);
    fr = frameOut;
    repeat (300) begin
      @(posedge clk_sys);
      if (commonLine > mx) mx = commonLine;
      if (frameOut !== fr) flips++;
      fr = frameOut;
    end
    `CHK(mx, top)
    `CHK(flips > 1, 1'b1)
  endtask : scan
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    rst = 1'b1;
    resetPinN = 1'b0;
    masterSel = 1'b1;
    frameIn = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    resetPinN <= 1'b1;
    repeat (10) @(posedge clk_sys);
    idle;
    ck(AS, 8'h60);
    ck(AK, 8'h03);
    wr(AC, 8'hB8);
    wr(AC, 8'h00);
    wr(AD, 8'h81);
    wr(AC, 8'h05);
    wr(AD, 8'hAA);
    wr(AD, 8'h55);
    wr(AC, 8'hB9);
    wr(AC, 8'h05);
    wr(AD, 8'h0F);
    wr(AC, 8'hB8);
    wr(AC, 8'h05);
    ck(AD, 8'hAA);
    ck(AD, 8'h55);
    wr(AC, 8'h4F);
    wr(AD, 8'h3C);
    wr(AD, 8'hC3);
    wr(AC, 8'h4F);
    ck(AD, 8'h3C);
    wr(AC, 8'h00);
    ck(AD, 8'h81);
    wr(AC, 8'h05);
    wr(AC, 8'hE0);
    ck(AD, 8'hAA);
    ck(AD, 8'hAA);
    wr(AD, 8'h11);
    ck(AD, 8'h55);
    wr(AC, 8'hEE);
    ck(AD, 8'h11);
    wr(AC, 8'h07);
    wr(AD, 8'h99);
    wr(AC, 8'h07);
    wr(AC, 8'hE2);
    idle;
    wr(AD, 8'h77);
    wr(AC, 8'hBB);
    wr(AC, 8'h07);
    ck(AD, 8'h77);
    wr(AC, 8'hB8);
    wr(AC, 8'h07);
    ck(AD, 8'h99);
    wr(AC, 8'hAF);
    ck(AS, 8'h40);
    wr(AC, 8'hAE);
    wr(AC, 8'hA5);
    ck(AK, 8'h0B);
    `CHK(commonActive, 1'b0)
    wr(AC, 8'hA4);
    ck(AK, 8'h03);
    ck(AS, 8'h60);
    wr(AC, 8'hA1);
    ck(AS, 8'h20);
    wr(AC, 8'hA0);
    ck(AS, 8'h60);
    wr(AC, 8'hA8);
    scan(5'h0F);
    wr(AC, 8'hA9);
    scan(5'h1F);
    wr(AC, 8'hAF);
    wr(AC, 8'hA1);
    resetPinN <= 1'b0;
    repeat (10) @(posedge clk_sys);
    idle;
    ck(AS, 8'h60);
    ck(AK, 8'h05);
    wr(8'h10, 8'h00);
    `CHK(lastErr, 1'b1)
    tally_and_finish;
  end
endmodule : tb
bind bitmap_lcd_command_core lcd_core_assertions #(
  .LINE_CYCLES(LINE_CYCLES)) chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .resetPinN(resetPinN), .masterSel(masterSel), .frameIn(frameIn),
  .frameOut(frameOut), .frameOe(frameOe), .commonLine(commonLine),
  .commonActive(commonActive), .commonDir(commonDir), .segLevel(segLevel));
